/* buck_defs.svh */
// timing counts and field constants for the buck mode and stepping control
`ifndef BUCK_DEFS_SVH
`define BUCK_DEFS_SVH

`define CLK_PERIOD_NS 25
`define OC_FAULT_TIME_US 8000
`define OC_FAULT_CYCLES ((`OC_FAULT_TIME_US * 1000) / `CLK_PERIOD_NS)
`define SOFT_SETTLE_TIME_US 3000
`define SOFT_SETTLE_CYCLES ((`SOFT_SETTLE_TIME_US * 1000) / `CLK_PERIOD_NS)
`define STEP_BASE_TIME_NS 2000
`define STEP_BASE_CYCLES (`STEP_BASE_TIME_NS / `CLK_PERIOD_NS)
`define STEP_SPEED_RESET 2'h1
`define BC_COARSE_BIT 6
`define STARTUP_DELAY_DEFAULT 1000

`endif

/* buck_pkg.sv */
// types shared by the buck mode and stepping control
package buck_pkg;
  typedef enum logic [1:0] {
    SW_OFF = 2'h0,
    SW_PFM = 2'h1,
    SW_APS = 2'h2,
    SW_PWM = 2'h3
  } sw_mode_t;

  typedef enum logic [4:0] {
    RAIL_OFF = 5'h01,
    RAIL_SOFT = 5'h02,
    RAIL_ON = 5'h04,
    RAIL_SLEEP = 5'h08,
    RAIL_WAIT = 5'h10
  } rail_state_t;
endpackage : buck_pkg

/* buck_rail.sv */
// one buck rail: mode decode, sleep handling, soft-start, voltage stepping, fault timer
`timescale 1ns/1ps
`default_nettype none
`include "buck_defs.svh"

module buck_rail #(
  parameter int VW = 7,
  parameter int HAS_COARSE = 1,
  parameter int OC_CYCLES = `OC_FAULT_CYCLES,
  parameter int SETTLE_CYCLES = `SOFT_SETTLE_CYCLES,
  parameter int STARTUP_DELAY = `STARTUP_DELAY_DEFAULT
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // settings
  input wire logic [3:0] mode_sel,
  input wire logic retain,
  input wire logic [VW-1:0] normal_sp,
  input wire logic [VW-1:0] standby_sp,
  input wire logic [VW-1:0] sleep_sp,
  input wire logic [1:0] step_speed,
  input wire logic [VW-1:0] default_sp,
  input wire logic [3:0] default_mode,
  // system events
  input wire logic standby,
  input wire logic turn_off,
  input wire logic turn_on,
  // analog status
  input wire logic over_current,
  input wire logic in_regulation,
  input wire logic heavy_load,
  // outputs
  output logic enable,
  output logic discharge,
  output logic cycle_limit,
  output var buck_pkg::sw_mode_t active_mode,
  output logic [VW-1:0] setpoint,
  output logic stepping,
  output logic fault_pulse,
  output logic mode_reserved
);

  ////////////////////////////////////////////////////////////////////////
  // mode field decode: normal and standby pairs; defaults rule from reset or any off state until the next sleep exit
  logic use_default;
  logic [3:0] eff_mode;
  assign eff_mode = use_default ? default_mode : mode_sel; // see RULE_13
  logic [1:0] dec_norm;
  logic [1:0] dec_stby;
  logic dec_rsvd;
  always_comb begin
    dec_norm = buck_pkg::SW_OFF; // see RULE_08
    dec_stby = buck_pkg::SW_OFF;
    dec_rsvd = 1'b0;
    case (eff_mode)
      4'h0: begin dec_norm = buck_pkg::SW_OFF; dec_stby = buck_pkg::SW_OFF; end
      4'h1: begin dec_norm = buck_pkg::SW_PWM; dec_stby = buck_pkg::SW_OFF; end
      4'h3: begin dec_norm = buck_pkg::SW_PFM; dec_stby = buck_pkg::SW_OFF; end
      4'h4: begin dec_norm = buck_pkg::SW_APS; dec_stby = buck_pkg::SW_OFF; end
      4'h5: begin dec_norm = buck_pkg::SW_PWM; dec_stby = buck_pkg::SW_PWM; end
      4'h6: begin dec_norm = buck_pkg::SW_PWM; dec_stby = buck_pkg::SW_APS; end
      4'h8: begin dec_norm = buck_pkg::SW_APS; dec_stby = buck_pkg::SW_APS; end
      4'hc: begin dec_norm = buck_pkg::SW_APS; dec_stby = buck_pkg::SW_PFM; end
      4'hd: begin dec_norm = buck_pkg::SW_PWM; dec_stby = buck_pkg::SW_PFM; end
      default: dec_rsvd = 1'b1; // reserved codes: rail treated as off
    endcase
  end
  assign mode_reserved = dec_rsvd;

  ////////////////////////////////////////////////////////////////////////
  // rail state machine
  buck_pkg::rail_state_t state;
  buck_pkg::rail_state_t next_state;
  logic [17:0] tcount;
  logic [17:0] next_tcount;
  logic next_use_default;
  logic [1:0] sel_mode;
  assign sel_mode = standby ? dec_stby : dec_norm; // see RULE_09

  always_comb begin
    next_state = state;
    next_tcount = tcount;
    next_use_default = use_default;
    case (state)
      buck_pkg::RAIL_OFF: begin
        next_tcount = '0;
        if (turn_on) begin
          next_state = buck_pkg::RAIL_WAIT;
        end
      end
      buck_pkg::RAIL_WAIT: begin
        // restart after the start-up delay, at default settings
        next_tcount = tcount + 18'h1;
        if (tcount >= 18'(STARTUP_DELAY)) begin // see RULE_13
          next_state = buck_pkg::RAIL_SOFT;
          next_tcount = '0;
        end
      end
      buck_pkg::RAIL_SOFT: begin
        if (in_regulation) begin
          next_tcount = tcount + 18'h1;
        end
        if (tcount >= 18'(SETTLE_CYCLES)) begin // see RULE_07
          next_state = buck_pkg::RAIL_ON;
          next_tcount = '0;
        end
        if (turn_off) begin
          next_state = retain ? buck_pkg::RAIL_SLEEP : buck_pkg::RAIL_OFF;
        end
      end
      buck_pkg::RAIL_ON: begin
        if (turn_off) begin
          next_state = retain ? buck_pkg::RAIL_SLEEP : buck_pkg::RAIL_OFF; // see RULE_11
        end
      end
      buck_pkg::RAIL_SLEEP: begin
        if (turn_on) begin
          next_state = buck_pkg::RAIL_ON; // see RULE_13
          next_use_default = 1'b0;
        end
      end
      default: next_state = buck_pkg::RAIL_OFF;
    endcase
  end

  // soft-start sequence: pfm before regulation, aps early in the settle wait, then pwm
  logic [1:0] soft_mode;
  assign soft_mode = (in_regulation && tcount >= 18'(SETTLE_CYCLES / 2)) ? buck_pkg::SW_PWM :
                     (tcount == '0 && !in_regulation) ? buck_pkg::SW_PFM :
                     buck_pkg::SW_APS; // see RULE_07

  logic [1:0] base_mode;
  always_comb begin
    case (state)
      buck_pkg::RAIL_ON: base_mode = dec_rsvd ? buck_pkg::SW_OFF : sel_mode; // see RULE_03
      buck_pkg::RAIL_SOFT: base_mode = soft_mode;
      buck_pkg::RAIL_SLEEP: base_mode = buck_pkg::SW_PFM; // see RULE_12
      default: base_mode = buck_pkg::SW_OFF;
    endcase
  end

  // aps resolves between pulse skipping and pwm from the load sense
  logic [1:0] next_mode;
  assign next_mode = (base_mode == buck_pkg::SW_APS && heavy_load) ? buck_pkg::SW_PWM :
                     base_mode; // see RULE_06

  ////////////////////////////////////////////////////////////////////////
  // target selection for the stepper
  logic [VW-1:0] target;
  assign target = (state == buck_pkg::RAIL_SLEEP) ? sleep_sp :
                  (state == buck_pkg::RAIL_SOFT || use_default) ? default_sp :
                  standby ? standby_sp : normal_sp; // see RULE_15

  // step period: base doubles per code, and doubles again for coarse codes
  logic coarse;
  assign coarse = (HAS_COARSE != 0) && target[VW-1]; // see RULE_18
  logic [12:0] period;
  assign period = 13'(`STEP_BASE_CYCLES) << (13'(step_speed) + 13'(coarse)); // see RULE_17
  logic [12:0] pcount;
  logic step_now;
  assign step_now = (pcount >= period - 13'h1);
  logic moving;
  assign moving = (setpoint != target);

  ////////////////////////////////////////////////////////////////////////
  // over-current fault timer, masked while stepping
  logic [18:0] oc_count;
  logic oc_done;
  // saturate one past the window so the fault pulses only once per over-current episode
  assign oc_done = (oc_count == 19'(OC_CYCLES) + 19'h1);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state <= buck_pkg::RAIL_OFF;
      tcount <= '0;
      use_default <= 1'b1;
      active_mode <= buck_pkg::SW_OFF;
      setpoint <= '0;
      pcount <= '0;
      oc_count <= '0;
      fault_pulse <= 1'b0;
    end else begin
      state <= next_state;
      tcount <= next_tcount;
      use_default <= (next_state == buck_pkg::RAIL_OFF) ? 1'b1 : next_use_default;
      active_mode <= buck_pkg::sw_mode_t'(next_mode); // see RULE_05
      // one step per period toward the target, stop on arrival
      if (!moving || state == buck_pkg::RAIL_OFF) begin
        pcount <= '0;
        if (state == buck_pkg::RAIL_OFF) setpoint <= default_sp;
      end else if (step_now) begin
        pcount <= '0;
        setpoint <= (setpoint < target) ? setpoint + 1'b1 : setpoint - 1'b1; // see RULE_21
      end else begin
        pcount <= pcount + 13'h1; // see RULE_14
      end
      // stepping masks the timer so a ramp inrush is not reported as a fault
      if (!over_current || moving) begin
        oc_count <= '0; // see RULE_19
      end else if (!oc_done) begin
        oc_count <= oc_count + 19'h1;
      end
      fault_pulse <= over_current && !moving && (oc_count == 19'(OC_CYCLES)); // see RULE_02
    end
  end

  // off means disabled with active discharge
  assign enable = (active_mode != buck_pkg::SW_OFF);
  assign discharge = (active_mode == buck_pkg::SW_OFF); // see RULE_04
  assign cycle_limit = over_current && enable; // see RULE_01
  assign stepping = moving; // see RULE_16

  ////////////////////////////////////////////////////////////////////////
  a_sleep_pfm: assert property (@(posedge clock) disable iff (sys_rst)
    state == buck_pkg::RAIL_SLEEP |=> active_mode == buck_pkg::SW_PFM) // see RULE_12
    else $error("sleep rail not in pfm");
  a_off_discharge: assert property (@(posedge clock) disable iff (sys_rst)
    state == buck_pkg::RAIL_OFF |=> discharge && !enable) // see RULE_04
    else $error("off rail not discharged");
  a_step_one: assert property (@(posedge clock) disable iff (sys_rst)
    $past(state) != buck_pkg::RAIL_OFF && state != buck_pkg::RAIL_OFF
      && setpoint != $past(setpoint) |->
      (setpoint == $past(setpoint) + 1'b1) || (setpoint == $past(setpoint) - 1'b1)) // see RULE_21
    else $error("set point jumped more than one step");
  a_fault_mask: assert property (@(posedge clock) disable iff (sys_rst)
    fault_pulse |-> $past(over_current) && !$past(moving)) // see RULE_19
    else $error("fault while stepping or without over-current");
  a_pwm_fixed: assert property (@(posedge clock) disable iff (sys_rst)
    state == buck_pkg::RAIL_ON && !standby && !dec_rsvd && dec_norm == buck_pkg::SW_PWM
      |=> active_mode == buck_pkg::SW_PWM) // see RULE_05
    else $error("pwm mode not held");
  a_retain_sleep: assert property (@(posedge clock) disable iff (sys_rst)
    state == buck_pkg::RAIL_ON && turn_off |=>
      state == (retain ? buck_pkg::RAIL_SLEEP : buck_pkg::RAIL_OFF)) // see RULE_11
    else $error("turn-off routed wrongly");
  a_step_period: assert property (@(posedge clock) disable iff (sys_rst)
    moving && state != buck_pkg::RAIL_OFF && pcount == 13'h0 && !step_now
      |=> setpoint == $past(setpoint)) // see RULE_17
    else $error("step before period elapsed");
  a_aps_load: assert property (@(posedge clock) disable iff (sys_rst)
    base_mode == buck_pkg::SW_APS |=> active_mode == ($past(heavy_load) ?
      buck_pkg::SW_PWM : buck_pkg::SW_APS)) // see RULE_06
    else $error("aps selection wrong");
  c_sleep: cover property (@(posedge clock) state == buck_pkg::RAIL_SLEEP);
  c_fault: cover property (@(posedge clock) fault_pulse);
  c_ramp: cover property (@(posedge clock) moving ##1 !moving);
endmodule : buck_rail

`default_nettype wire

/* buck_ctrl.sv */
// top of the buck mode and voltage stepping control for three rails
`timescale 1ns/1ps
`default_nettype none
`include "buck_defs.svh"

// Behaviour
// RULE_01: over-current limits current each cycle, no immediate shutdown
// RULE_02: over-current lasting over 8.0 ms raises that rail's fault
// RULE_03: mode follows writes, standby, sleep and load changes
// RULE_04: off mode disables the rail and discharges its output
// RULE_05: pfm and pwm modes hold their operation regardless of load
// RULE_06: aps picks pulse skipping or pwm from present load
// RULE_07: soft-start runs pfm, aps, pwm; selected mode 3.0 ms after regulation
// RULE_08: four-bit mode field decodes normal/standby pairs, others reserved
// RULE_09: standby uses standby set point and mode; exit restores normal
// RULE_10: normal and standby set points accept the same code range
// RULE_11: turn-off sends retained rails to sleep, others off
// RULE_12: sleep uses sleep set point in pfm; 6 or 7 bit fields
// RULE_13: turn-on ends sleep; off rails restart after start-up delay at defaults
// RULE_14: normal set point from normal field, written changes ramp
// RULE_15: standby low selects normal field, high selects standby field
// RULE_16: standby and turn-off transitions ramp at the step-speed rate
// RULE_17: first rail steps 25 mV each 2, 4, 8 or 16 us; default 01
// RULE_18: other rails double period at 50 mV when bit 6 set
// RULE_19: fault detection masked during a stepping ramp
// RULE_20: active-high power button low is a turn-off event
// RULE_21: stepper moves one step per period toward target, then stops

module buck_ctrl #(
  parameter int OC_CYCLES = `OC_FAULT_CYCLES,
  parameter int SETTLE_CYCLES = `SOFT_SETTLE_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // host settings
  input wire logic [3:0] buck_a_mode_sel,
  input wire logic [3:0] buck_b_mode_sel,
  input wire logic [3:0] buck_c_mode_sel,
  input wire logic [2:0] sleep_retain_sel,
  input wire logic [5:0] buck_a_normal_setpoint,
  input wire logic [5:0] buck_a_standby_setpoint,
  input wire logic [5:0] buck_a_sleep_setpoint,
  input wire logic [13:0] buck_bc_normal_setpoint,
  input wire logic [13:0] buck_bc_standby_setpoint,
  input wire logic [13:0] buck_bc_sleep_setpoint,
  input wire logic [1:0] buck_a_step_speed,
  input wire logic [3:0] buck_bc_step_speed,
  // power-on defaults
  input wire logic [5:0] buck_a_default_setpoint,
  input wire logic [13:0] buck_bc_default_setpoint,
  input wire logic [11:0] default_mode_sel,
  // system events
  input wire logic standby,
  input wire logic power_button_in,
  input wire logic power_button_cfg,
  input wire logic turn_on,
  // analog status per rail
  input wire logic [2:0] over_current,
  input wire logic [2:0] in_regulation,
  input wire logic [2:0] heavy_load,
  // rail controls
  output logic [2:0] rail_enable,
  output logic [2:0] rail_discharge,
  output logic [2:0] rail_cycle_limit,
  output logic [5:0] rail_mode,
  output logic [5:0] buck_a_setpoint,
  output logic [13:0] buck_bc_setpoint,
  output logic [2:0] voltage_stepping,
  output logic [2:0] rail_fault,
  output logic [2:0] mode_reserved
);

  ////////////////////////////////////////////////////////////////////////
  // turn-off event: falling level on an active-high button
  logic button_prev;
  logic turn_off;
  always_ff @(posedge clock) begin
    if (sys_rst) button_prev <= 1'b1;
    else button_prev <= power_button_in;
  end
  // only the level mode is handled here; switch mode debounce lives elsewhere
  assign turn_off = !power_button_cfg && button_prev && !power_button_in; // see RULE_20

  ////////////////////////////////////////////////////////////////////////
  // rail a: six-bit codes, fine steps only
  buck_pkg::sw_mode_t mode_a;
  buck_rail #(.VW(6), .HAS_COARSE(0), .OC_CYCLES(OC_CYCLES),
    .SETTLE_CYCLES(SETTLE_CYCLES)) u_rail_a (
    .clock(clock), .sys_rst(sys_rst),
    .mode_sel(buck_a_mode_sel), .retain(sleep_retain_sel[0]),
    .normal_sp(buck_a_normal_setpoint), .standby_sp(buck_a_standby_setpoint), // see RULE_10
    .sleep_sp(buck_a_sleep_setpoint), .step_speed(buck_a_step_speed),
    .default_sp(buck_a_default_setpoint), .default_mode(default_mode_sel[3:0]),
    .standby(standby), .turn_off(turn_off), .turn_on(turn_on),
    .over_current(over_current[0]), .in_regulation(in_regulation[0]),
    .heavy_load(heavy_load[0]),
    .enable(rail_enable[0]), .discharge(rail_discharge[0]),
    .cycle_limit(rail_cycle_limit[0]), .active_mode(mode_a),
    .setpoint(buck_a_setpoint), .stepping(voltage_stepping[0]),
    .fault_pulse(rail_fault[0]), .mode_reserved(mode_reserved[0])
  );
  assign rail_mode[1:0] = mode_a;

  ////////////////////////////////////////////////////////////////////////
  // rails b and c: seven-bit codes, coarse steps when bit 6 is set
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_bc
      buck_pkg::sw_mode_t mode_bc;
      buck_rail #(.VW(7), .HAS_COARSE(1), .OC_CYCLES(OC_CYCLES),
        .SETTLE_CYCLES(SETTLE_CYCLES)) u_rail (
        .clock(clock), .sys_rst(sys_rst),
        .mode_sel(g == 0 ? buck_b_mode_sel : buck_c_mode_sel),
        .retain(sleep_retain_sel[g+1]),
        .normal_sp(buck_bc_normal_setpoint[g*7 +: 7]),
        .standby_sp(buck_bc_standby_setpoint[g*7 +: 7]),
        .sleep_sp(buck_bc_sleep_setpoint[g*7 +: 7]),
        .step_speed(buck_bc_step_speed[g*2 +: 2]),
        .default_sp(buck_bc_default_setpoint[g*7 +: 7]),
        .default_mode(default_mode_sel[(g+1)*4 +: 4]),
        .standby(standby), .turn_off(turn_off), .turn_on(turn_on),
        .over_current(over_current[g+1]), .in_regulation(in_regulation[g+1]),
        .heavy_load(heavy_load[g+1]),
        .enable(rail_enable[g+1]), .discharge(rail_discharge[g+1]),
        .cycle_limit(rail_cycle_limit[g+1]), .active_mode(mode_bc),
        .setpoint(buck_bc_setpoint[g*7 +: 7]), .stepping(voltage_stepping[g+1]),
        .fault_pulse(rail_fault[g+1]), .mode_reserved(mode_reserved[g+1])
      );
      assign rail_mode[(g+1)*2 +: 2] = mode_bc;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  a_turn_off_edge: assert property (@(posedge clock) disable iff (sys_rst)
    !power_button_cfg && $fell(power_button_in) |-> turn_off) // see RULE_20
    else $error("button fall missed");
  c_turn_off: cover property (@(posedge clock) turn_off);
endmodule : buck_ctrl

`default_nettype wire

/* host_model.sv */
// host side model: settings written over the serial bus plus the standby and button lines
`timescale 1ns/1ps
`default_nettype none

module host_model (
  // mode and retention settings
  output var logic [3:0] buck_a_mode_sel,
  output var logic [3:0] buck_b_mode_sel,
  output var logic [3:0] buck_c_mode_sel,
  output var logic [2:0] sleep_retain_sel,
  // set point fields
  output var logic [5:0] buck_a_normal_setpoint,
  output var logic [5:0] buck_a_standby_setpoint,
  output var logic [5:0] buck_a_sleep_setpoint,
  output var logic [13:0] buck_bc_normal_setpoint,
  output var logic [13:0] buck_bc_standby_setpoint,
  output var logic [13:0] buck_bc_sleep_setpoint,
  // stepping speed fields
  output var logic [1:0] buck_a_step_speed,
  output var logic [3:0] buck_bc_step_speed,
  // system lines
  output var logic standby,
  output var logic power_button_in,
  output var logic power_button_cfg
);
  // power-up values of the host registers; the bench rewrites them off the sampling edge
  initial begin
    buck_a_mode_sel = 4'h5;
    buck_b_mode_sel = 4'h5;
    buck_c_mode_sel = 4'h5;
    sleep_retain_sel = 3'h3; // rail c not retained, so it powers off
    buck_a_normal_setpoint = 6'h12;
    buck_a_standby_setpoint = 6'h12;
    buck_a_sleep_setpoint = 6'h12;
    buck_bc_normal_setpoint = {7'h10, 7'h10};
    buck_bc_standby_setpoint = {7'h10, 7'h10};
    buck_bc_sleep_setpoint = {7'h10, 7'h10};
    buck_a_step_speed = 2'h1; // reset speed code
    buck_bc_step_speed = 4'h5;
    standby = 1'b0;
    power_button_in = 1'b1; // active-high level, idle high
    power_button_cfg = 1'b0;
  end
endmodule : host_model

`default_nettype wire

/* testbench.sv */
// self-checking bench for the three-rail buck mode and stepping control
`timescale 1ns/1ps
`default_nettype none

module testbench;
  localparam int OC = 50;
  localparam int SETTLE = 20;
  logic clock, sys_rst, turn_on;
  logic [2:0] over_current, in_regulation, heavy_load;
  logic [3:0] a_mode, b_mode, c_mode;
  logic [2:0] retain;
  logic [5:0] a_nsp, a_ssp, a_lsp, a_sp;
  logic [13:0] bc_nsp, bc_ssp, bc_lsp, bc_sp;
  logic [1:0] a_spd;
  logic [3:0] bc_spd;
  logic standby, button, button_cfg;
  logic [2:0] rail_enable, rail_discharge, rail_cycle_limit, voltage_stepping, rail_fault;
  logic [2:0] mode_reserved;
  logic [5:0] rail_mode;
  int error_cnt = 0;
  int samples_checked = 0;

  ////////////////////////////////////////////////////////////////////////////
  // clock, partner and design
  always #12.5 clock = ~clock;

  host_model u_host_model (.buck_a_mode_sel(a_mode), .buck_b_mode_sel(b_mode),
    .buck_c_mode_sel(c_mode), .sleep_retain_sel(retain), .buck_a_normal_setpoint(a_nsp),
    .buck_a_standby_setpoint(a_ssp), .buck_a_sleep_setpoint(a_lsp),
    .buck_bc_normal_setpoint(bc_nsp), .buck_bc_standby_setpoint(bc_ssp),
    .buck_bc_sleep_setpoint(bc_lsp), .buck_a_step_speed(a_spd), .buck_bc_step_speed(bc_spd),
    .standby(standby), .power_button_in(button), .power_button_cfg(button_cfg));

  buck_ctrl #(.OC_CYCLES(OC), .SETTLE_CYCLES(SETTLE)) u_buck_ctrl (.clock(clock),
    .sys_rst(sys_rst), .buck_a_mode_sel(a_mode), .buck_b_mode_sel(b_mode),
    .buck_c_mode_sel(c_mode), .sleep_retain_sel(retain), .buck_a_normal_setpoint(a_nsp),
    .buck_a_standby_setpoint(a_ssp), .buck_a_sleep_setpoint(a_lsp),
    .buck_bc_normal_setpoint(bc_nsp), .buck_bc_standby_setpoint(bc_ssp),
    .buck_bc_sleep_setpoint(bc_lsp), .buck_a_step_speed(a_spd), .buck_bc_step_speed(bc_spd),
    .buck_a_default_setpoint(6'h10), .buck_bc_default_setpoint({7'h10, 7'h10}),
    .default_mode_sel({4'h5, 4'h5, 4'h4}), .standby(standby), .power_button_in(button),
    .power_button_cfg(button_cfg), .turn_on(turn_on), .over_current(over_current),
    .in_regulation(in_regulation), .heavy_load(heavy_load), .rail_enable(rail_enable),
    .rail_discharge(rail_discharge), .rail_cycle_limit(rail_cycle_limit),
    .rail_mode(rail_mode), .buck_a_setpoint(a_sp), .buck_bc_setpoint(bc_sp),
    .voltage_stepping(voltage_stepping), .rail_fault(rail_fault),
    .mode_reserved(mode_reserved));

  ////////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic check(input bit ok, input string msg);
    samples_checked++;
    if (!ok) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic cycles(input int n);
    repeat (n) @(negedge clock);
  endtask : cycles

  function automatic logic [6:0] cur_sp(input int r);
    case (r)
      0: cur_sp = {1'b0, a_sp};
      1: cur_sp = bc_sp[6:0];
      default: cur_sp = bc_sp[13:7];
    endcase
  endfunction : cur_sp

  // cycles between two consecutive set point moves; skips the partial first period
  task automatic step_period(input int r, input int exp_p);
    logic [6:0] last;
    int n;
    for (int k = 0; k < 2; k++) begin
      last = cur_sp(r);
      n = 0;
      while (cur_sp(r) === last && n < 3000) begin
        cycles(1);
        n++;
      end
    end
    check(n == exp_p, "step period");
  endtask : step_period

  task automatic wait_idle(input int r, input int limit, input logic [6:0] exp_sp);
    int n;
    n = 0;
    while (voltage_stepping[r] !== 1'b0 && n < limit) begin
      cycles(1);
      n++;
    end
    check(cur_sp(r) === exp_sp, "ramp end value");
  endtask : wait_idle

  task automatic pulse_on;
    turn_on = 1'b1;
    cycles(1);
    turn_on = 1'b0;
  endtask : pulse_on

  // {reserved, normal mode, standby mode}; 0 off 1 pfm 2 aps 3 pwm
  function automatic logic [4:0] mode_pair(input logic [3:0] code);
    case (code)
      4'h0: mode_pair = 5'h00;
      4'h1: mode_pair = 5'h0c;
      4'h3: mode_pair = 5'h04;
      4'h4: mode_pair = 5'h08;
      4'h5: mode_pair = 5'h0f;
      4'h6: mode_pair = 5'h0e;
      4'h8: mode_pair = 5'h0a;
      4'hc: mode_pair = 5'h09;
      4'hd: mode_pair = 5'h0d;
      default: mode_pair = 5'h10;
    endcase
  endfunction : mode_pair

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_startup;
    int n;
    pulse_on();
    n = 0;
    while (rail_mode === 6'h00 && n < 1200) begin
      cycles(1);
      n++;
    end
    check(rail_mode === 6'h15, "soft-start not in pfm");
    in_regulation = 3'h7;
    cycles(2);
    check(rail_mode === 6'h2a, "soft-start not in aps at regulation");
    cycles(SETTLE / 2);
    check(rail_mode === 6'h3f, "soft-start not in pwm");
    cycles(SETTLE / 2 + 4);
    check(rail_mode === 6'h3e, "selected mode not reached");
    heavy_load = 3'h3;
    cycles(2);
    check(rail_mode[1:0] === 2'h3, "aps not pwm at heavy load");
    check(rail_mode[5:2] === 4'hf, "pwm moved with load");
    heavy_load = 3'h0;
    cycles(2);
    check(rail_mode[1:0] === 2'h2, "aps not skipping at light load");
  endtask : t_startup

  task automatic t_sleep;
    u_host_model.buck_a_sleep_setpoint = 6'h14;
    u_host_model.power_button_in = 1'b0; // level falls: turn-off event
    cycles(3);
    check(rail_mode === 6'h05, "sleep modes wrong");
    check(rail_enable === 3'h3 && rail_discharge === 3'h4, "off rail not off");
    check(cur_sp(2) === 7'h10, "off rail set point not default");
    step_period(0, 160);
    wait_idle(0, 1000, 7'h14);
    u_host_model.power_button_in = 1'b1;
    pulse_on();
    cycles(2);
    check(rail_mode[3:0] === 4'hf, "retained rails not on normal mode");
    wait_idle(0, 1000, 7'h12);
  endtask : t_sleep

  task automatic t_button_cfg;
    u_host_model.power_button_cfg = 1'b1;
    u_host_model.power_button_in = 1'b0;
    cycles(4);
    check(rail_mode[3:0] === 4'hf, "turn-off taken with switch config");
    u_host_model.power_button_in = 1'b1;
    cycles(1);
    u_host_model.power_button_cfg = 1'b0;
  endtask : t_button_cfg

  task automatic t_mode_table;
    logic [4:0] e;
    for (int c = 0; c < 16; c++) begin
      e = mode_pair(4'(c));
      u_host_model.buck_b_mode_sel = 4'(c);
      cycles(2);
      check(rail_mode[3:2] === e[3:2] && mode_reserved[1] === e[4], "normal mode");
      check(rail_enable[1] === (e[3:2] != 2'h0), "enable vs mode");
      u_host_model.standby = 1'b1;
      cycles(2);
      check(rail_mode[3:2] === e[1:0], "standby mode");
      u_host_model.standby = 1'b0;
    end
    u_host_model.buck_b_mode_sel = 4'h5;
    cycles(2);
    check(rail_mode[3:2] === 2'h3, "mode write not applied");
  endtask : t_mode_table

  task automatic t_standby_ramp;
    u_host_model.buck_bc_step_speed = 4'h0;
    u_host_model.buck_bc_standby_setpoint = {7'h10, 7'h12};
    u_host_model.standby = 1'b1;
    step_period(1, 80);
    wait_idle(1, 1000, 7'h12);
    u_host_model.buck_bc_standby_setpoint = {7'h10, 7'h40};
    step_period(1, 160);
    wait_idle(1, 8000, 7'h40);
    u_host_model.standby = 1'b0;
    step_period(1, 80);
    wait_idle(1, 5000, 7'h10);
  endtask : t_standby_ramp

  task automatic t_speeds;
    for (int s = 0; s < 4; s++) begin
      u_host_model.buck_a_step_speed = 2'(s);
      u_host_model.buck_a_normal_setpoint = a_nsp + 6'h2;
      step_period(0, 80 << s);
      wait_idle(0, 2000, {1'b0, a_nsp});
    end
  endtask : t_speeds

  task automatic t_fault;
    int n;
    int hits;
    over_current[0] = 1'b1;
    n = 0;
    while (rail_fault[0] !== 1'b1 && n < 200) begin
      cycles(1);
      n++;
      check(rail_cycle_limit[0] === 1'b1 && rail_enable[0] === 1'b1, "limit");
    end
    check(n == OC + 1, "fault timing");
    hits = 0;
    repeat (2 * OC) begin
      cycles(1);
      hits += int'(rail_fault[0] === 1'b1);
    end
    check(hits == 0, "fault repeated or too long");
    over_current[0] = 1'b0;
    cycles(2);
    u_host_model.buck_a_normal_setpoint = a_nsp + 6'h3;
    over_current[0] = 1'b1;
    repeat (OC + 40) begin
      cycles(1);
      hits += int'(rail_fault[0] === 1'b1);
    end
    check(hits == 0, "fault during ramp");
    over_current[0] = 1'b0;
    wait_idle(0, 3000, {1'b0, a_nsp});
  endtask : t_fault

  ////////////////////////////////////////////////////////////////////////////
  // verdict, watchdog and main sequence
  task automatic finish_test;
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  // the whole sequence needs about 20000 cycles; twice that means a hang
  initial begin
    #(40000 * 25);
    error_cnt++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    finish_test();
  end

  initial begin
    clock = 1'b0;
    sys_rst = 1'b1;
    turn_on = 1'b0;
    over_current = 3'h0;
    in_regulation = 3'h0;
    heavy_load = 3'h0;
    cycles(8);
    check(rail_mode === 6'h00 && rail_discharge === 3'h7, "reset state");
    check(rail_fault === 3'h0, "fault at reset");
    sys_rst = 1'b0;
    cycles(2);
    t_startup();
    t_sleep();
    t_button_cfg();
    t_mode_table();
    t_standby_ramp();
    t_speeds();
    t_fault();
    finish_test();
  end
endmodule : testbench

`default_nettype wire
